// ---- rtl/pbp_pkg.sv ----
// package with address map, field layout, reset values and shared types of the buffer port
package pbp_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int EVT_W  = 4;

  // address map of the host port
  localparam logic [ADDR_W-1:0] ADDR_EP_WR    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_EP_RD    = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_CFG      = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MASK     = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_EVT      = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_READY    = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_RDY_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_NONE     = 8'hFF;

  // configuration fields
  localparam int CFG_SYNC_BIT = 0;
  localparam int CFG_DMA_BIT  = 1;
  localparam int CFG_W        = 2;
  localparam logic [CFG_W-1:0] CFG_RESET  = 2'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;

  // event bits
  localparam int EVT_RD_READY = 0;
  localparam int EVT_WR_READY = 1;
  localparam int EVT_OVERFLOW = 2;
  localparam int EVT_UNDERRUN = 3;

  // ready register bits
  localparam int RDY_RD_BIT = 0;
  localparam int RDY_WR_BIT = 1;

  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    PBP_ACC_IDLE = 2'b01,
    PBP_ACC_HOLD = 2'b10
  } pbp_acc_t;

  // host memory bus control and address
  typedef struct packed {
    logic              ce_n;
    logic              adv_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
  } pbp_bus_t;

  // whole register state of the port outside its two endpoint buffers
  typedef struct packed {
    pbp_acc_t          acc;
    logic [CFG_W-1:0]  cfg;
    logic [EVT_W-1:0]  mask;
    logic [EVT_W-1:0]  evt;
    logic [DATA_W-1:0] rdata;
    logic              drive;
    logic              dreq_n;
    logic              irq_n;
    logic              rd_rdy_prev;
    logic              wr_rdy_prev;
  } pbp_st_t;

endpackage

// ---- rtl/pbp_fifo.sv ----
// parameterised fifo between host port and core side of one endpoint buffer
`timescale 1ns/1ps
`default_nettype none
module pbp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // drain side
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } pbp_fifo_st_t;

  pbp_fifo_st_t st_q;
  pbp_fifo_st_t st_d;
  logic         push;
  logic         pop;

  assign in_ready_out  = (st_q.cnt != CNT_FULL);
  assign out_valid_out = (st_q.cnt != '0);
  assign out_data_out  = st_q.mem[st_q.rp];

  always_comb begin
    st_d = st_q;
    push = in_valid_in & in_ready_out;
    pop  = out_valid_out & out_ready_in;
    if (push) begin
      st_d.mem[st_q.wp] = in_data_in;
      st_d.wp = (st_q.wp == PTR_LAST) ? '0 : st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = (st_q.rp == PTR_LAST) ? '0 : st_q.rp + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pbp_port.sv ----
// processor buffer port: host memory bus slave with endpoint buffers, dma request and interrupt
// Behaviour
// - accept synchronous and asynchronous sram style accesses
// - address selects one of the endpoint buffers
// - dma request or interrupt signalling, host selects
// - dma mode: request asserted while buffer ready
// - interrupt mode: interrupt reports buffer status changes
// - mask register keeps sources off the interrupt
// - status shows conditions and the read buffer address while it holds data
// - registers mapped on same port as data
`timescale 1ns/1ps
`default_nettype none
module pbp_port
  import pbp_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  // host memory bus
  input  wire pbp_bus_t          host_bus_in,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_n_out,
  // host signalling
  output logic                   int_n_out,
  output logic                   dma_request_out_n,
  input  wire logic              dma_ack_in_n,
  // core side of the host-to-core buffer
  output logic      [DATA_W-1:0] core_rx_data_out,
  output logic                   core_rx_valid_out,
  input  wire logic              core_rx_ready_in,
  // core side of the core-to-host buffer
  input  wire logic [DATA_W-1:0] core_tx_data_in,
  input  wire logic              core_tx_valid_in,
  output logic                   core_tx_ready_out
);
  // register values while reset is held: both signalling pins inactive
  localparam pbp_st_t ST_RESET = '{
    acc:         PBP_ACC_IDLE,
    cfg:         CFG_RESET,
    mask:        MASK_RESET,
    evt:         '0,
    rdata:       DATA_ZERO,
    drive:       1'b0,
    dreq_n:      1'b1,
    irq_n:       1'b1,
    rd_rdy_prev: 1'b0,
    wr_rdy_prev: 1'b0
  };

  pbp_st_t           st_q;
  pbp_st_t           st_d;
  logic              wr_push;
  logic              wr_ready;
  logic              rd_pop;
  logic              rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic              sel;
  logic              is_wr;
  logic              is_rd;
  logic              take;
  logic              dma_ack;
  logic              tgt_wr_ep;
  logic              tgt_rd_ep;
  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;
  // one decoded hit per mapped address
  logic              hit_ep_wr;
  logic              hit_ep_rd;
  logic              hit_cfg;
  logic              hit_mask;
  logic              hit_evt;
  logic              hit_ready;
  logic              hit_rdy_addr;
  logic [1:0]        ep_ready;

  // host writes land here; the core drains it
  pbp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_buf (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (dq_in),
    .in_valid_in   (wr_push),
    .in_ready_out  (wr_ready),
    .out_data_out  (core_rx_data_out),
    .out_valid_out (core_rx_valid_out),
    .out_ready_in  (core_rx_ready_in)
  );

  // the core fills this one; the host reads it
  pbp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_buf (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (core_tx_data_in),
    .in_valid_in   (core_tx_valid_in),
    .in_ready_out  (core_tx_ready_out),
    .out_data_out  (rd_data),
    .out_valid_out (rd_valid),
    .out_ready_in  (rd_pop)
  );

  assign dq_out            = st_q.rdata;
  assign dq_oe_n_out       = ~st_q.drive;
  assign int_n_out         = st_q.irq_n;
  assign dma_request_out_n = st_q.dreq_n;

  // address decode, shared by the read and write paths
  assign hit_ep_wr    = (host_bus_in.addr == ADDR_EP_WR);
  assign hit_ep_rd    = (host_bus_in.addr == ADDR_EP_RD);
  assign hit_cfg      = (host_bus_in.addr == ADDR_CFG);
  assign hit_mask     = (host_bus_in.addr == ADDR_MASK);
  assign hit_evt      = (host_bus_in.addr == ADDR_EVT);
  assign hit_ready    = (host_bus_in.addr == ADDR_READY);
  assign hit_rdy_addr = (host_bus_in.addr == ADDR_RDY_ADDR);

  // one ready flag per endpoint buffer, in the layout of the ready register
  assign ep_ready[RDY_RD_BIT] = rd_valid;
  assign ep_ready[RDY_WR_BIT] = wr_ready;

  always_comb begin
    st_d    = st_q;
    sel     = ~host_bus_in.ce_n;
    is_wr   = ~host_bus_in.we_n;
    is_rd   = ~host_bus_in.oe_n & host_bus_in.we_n;
    dma_ack = ~dma_ack_in_n;
    take    = 1'b0;
    evt_set = '0;
    evt_clr = '0;

    // one access per address-valid clock, or one per strobe when asynchronous
    if (st_q.cfg[CFG_SYNC_BIT]) begin
      take     = sel & ~host_bus_in.adv_n & (is_wr | is_rd);
      st_d.acc = PBP_ACC_IDLE;
    end else begin
      case (st_q.acc)
        PBP_ACC_IDLE: begin
          take = sel & (is_wr | is_rd);
          if (take) begin
            st_d.acc = PBP_ACC_HOLD;
          end
        end
        // no new access until the strobe ends
        PBP_ACC_HOLD: begin
          if (!sel || (host_bus_in.we_n && host_bus_in.oe_n)) begin
            st_d.acc = PBP_ACC_IDLE;
          end
        end
        default: begin
          st_d.acc = PBP_ACC_IDLE;
        end
      endcase
    end

    // dma acknowledge steers the access to a buffer whatever the address
    tgt_wr_ep = is_wr & (dma_ack | hit_ep_wr);
    tgt_rd_ep = is_rd & (dma_ack | hit_ep_rd);
    wr_push   = take & tgt_wr_ep;
    rd_pop    = take & tgt_rd_ep;
    evt_set[EVT_OVERFLOW] = wr_push & ~wr_ready;
    evt_set[EVT_UNDERRUN] = rd_pop & ~rd_valid;
    evt_set[EVT_RD_READY] = rd_valid & ~st_q.rd_rdy_prev;
    evt_set[EVT_WR_READY] = wr_ready & ~st_q.wr_rdy_prev;

    // read data is registered and stands until the next read
    st_d.drive = sel & is_rd;
    if (take && is_rd) begin
      st_d.rdata = DATA_ZERO;
      if (tgt_rd_ep) begin
        st_d.rdata = rd_valid ? rd_data : DATA_ZERO;
      end else if (hit_cfg) begin
        st_d.rdata = {{(DATA_W-CFG_W){1'b0}}, st_q.cfg};
      end else if (hit_mask) begin
        st_d.rdata = {{(DATA_W-EVT_W){1'b0}}, st_q.mask};
      end else if (hit_evt) begin
        st_d.rdata = {{(DATA_W-EVT_W){1'b0}}, st_q.evt};
      end else if (hit_ready) begin
        st_d.rdata = {{(DATA_W-2){1'b0}}, ep_ready};
      end else if (hit_rdy_addr) begin
        st_d.rdata = {{(DATA_W-ADDR_W){1'b0}}, (rd_valid ? ADDR_EP_RD : ADDR_NONE)};
      end
    end

    // writes to a buffer never reach a register
    if (take && is_wr && !tgt_wr_ep) begin
      if (hit_cfg) begin
        st_d.cfg = dq_in[CFG_W-1:0];
      end else if (hit_mask) begin
        st_d.mask = dq_in[EVT_W-1:0];
      end else if (hit_evt) begin
        evt_clr = dq_in[EVT_W-1:0];
      end
    end

    // a new event wins over a clear in the same cycle
    st_d.evt         = (st_q.evt & ~evt_clr) | evt_set;
    st_d.rd_rdy_prev = rd_valid;
    st_d.wr_rdy_prev = wr_ready;

    // the unused signalling pin stays inactive
    st_d.dreq_n = ~(st_d.cfg[CFG_DMA_BIT] & |ep_ready);
    st_d.irq_n  = ~(~st_d.cfg[CFG_DMA_BIT] & |(st_d.evt & st_d.mask));
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

// ---- verif/pbp_port_checker.sv ----
// assertion checker bound to the processor buffer port
`timescale 1ns/1ps
`default_nettype none
module pbp_port_checker
  import pbp_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // watched ports
  input wire logic              core_clk_in,
  input wire logic              rst_n_in,
  input wire pbp_bus_t          host_bus_in,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe_n_out,
  input wire logic              int_n_out,
  input wire logic              dma_request_out_n,
  input wire logic              dma_ack_in_n,
  input wire logic [DATA_W-1:0] core_rx_data_out,
  input wire logic              core_rx_valid_out,
  input wire logic              core_rx_ready_in,
  input wire logic [DATA_W-1:0] core_tx_data_in,
  input wire logic              core_tx_valid_in,
  input wire logic              core_tx_ready_out
);
  localparam int FW = $clog2(FIFO_DEPTH + 1);
  localparam logic [FW-1:0] FILL_FULL = FW'(FIFO_DEPTH);
  pbp_bus_t         b;
  logic [CFG_W-1:0] cfg_q;
  logic [EVT_W-1:0] mask_q;
  logic [FW-1:0]    fill_q;
  logic             busy_q;
  logic             stb;
  logic             tk;
  logic             tx_push;
  logic             tx_pop;
  assign b   = host_bus_in;
  assign stb = !b.ce_n && !(b.we_n && b.oe_n);
  assign tk  = stb && (cfg_q[CFG_SYNC_BIT] ? !b.adv_n : !busy_q);
  assign tx_push = core_tx_valid_in && core_tx_ready_out;
  assign tx_pop  = tk && b.we_n && !b.oe_n && fill_q != '0 &&
                   (b.addr == ADDR_EP_RD || !dma_ack_in_n);
  // shadow of mode, mask and read buffer fill as seen at the pins
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cfg_q  <= CFG_RESET;
      mask_q <= MASK_RESET;
      fill_q <= '0;
      busy_q <= 1'b0;
    end else begin
      busy_q <= stb;
      if (tx_push && !tx_pop) begin
        fill_q <= fill_q + 1'b1;
      end else if (tx_pop && !tx_push) begin
        fill_q <= fill_q - 1'b1;
      end
      if (tk && !b.we_n && dma_ack_in_n && b.addr == ADDR_CFG) begin
        cfg_q <= dq_in[CFG_W-1:0];
      end
      if (tk && !b.we_n && dma_ack_in_n && b.addr == ADDR_MASK) begin
        mask_q <= dq_in[EVT_W-1:0];
      end
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_oe_on; !b.ce_n && !b.oe_n && b.we_n |=> !dq_oe_n_out; endproperty
  a_oe_on: assert property (p_oe_on) else $error("dq not driven on read");
  property p_oe_off; b.ce_n |=> dq_oe_n_out; endproperty
  a_oe_off: assert property (p_oe_off) else $error("dq driven when idle");
  property p_rx_push;
    tk && !b.we_n && (b.addr == ADDR_EP_WR || !dma_ack_in_n) |=> core_rx_valid_out;
  endproperty
  a_rx_push: assert property (p_rx_push) else $error("write lost");
  property p_rx_hold;
    core_rx_valid_out && !core_rx_ready_in |=> core_rx_valid_out && $stable(core_rx_data_out);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx word not held");
  property p_int_off; cfg_q[CFG_DMA_BIT] |-> int_n_out; endproperty
  a_int_off: assert property (p_int_off) else $error("int in dma mode");
  property p_dma_off; !cfg_q[CFG_DMA_BIT] |-> dma_request_out_n; endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma req in int mode");
  property p_dma_on; cfg_q[CFG_DMA_BIT] && !core_tx_ready_out |=> !dma_request_out_n; endproperty
  a_dma_on: assert property (p_dma_on) else $error("no dma req");
  property p_mask; mask_q == MASK_RESET |-> int_n_out; endproperty
  a_mask: assert property (p_mask) else $error("int with all masked");
  property p_tx_ready; core_tx_ready_out == (fill_q != FILL_FULL); endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("read buffer ready wrong");
  property p_cfg_rd;
    tk && b.we_n && !b.oe_n && dma_ack_in_n && b.addr == ADDR_CFG
      |=> dq_out == DATA_W'($past(cfg_q));
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong");
  c_dma: cover property (!dma_request_out_n);
  c_int: cover property (!int_n_out);
  c_stall: cover property (core_rx_valid_out && !core_rx_ready_in);
endmodule
bind pbp_port pbp_port_checker #(.FIFO_DEPTH(FIFO_DEPTH)) pbp_port_checker_i (
  .core_clk_in, .rst_n_in, .host_bus_in, .dq_in, .dq_out, .dq_oe_n_out, .int_n_out,
  .dma_request_out_n, .dma_ack_in_n, .core_rx_data_out, .core_rx_valid_out,
  .core_rx_ready_in, .core_tx_data_in, .core_tx_valid_in, .core_tx_ready_out);
`default_nettype wire

// ---- verif/pbp_host.sv ----
// host processor model on the memory bus of the buffer port
`timescale 1ns/1ps
`default_nettype none
module pbp_host
  import pbp_pkg::*;
(
  // clock
  input  wire logic              core_clk_in,
  // memory bus
  output var pbp_bus_t           bus_out,
  output var logic  [DATA_W-1:0] dq_out
);
  initial begin
    bus_out = '{1'b1, 1'b1, 1'b1, 1'b1, ADDR_NONE};
    dq_out  = DATA_ZERO;
  end
  // data moves only by strobes on the memory port, one edge on, one off
  task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dat);
    bus_out <= '{1'b0, 1'b0, wr, !wr, a};
    dq_out  <= dat;
    @(posedge core_clk_in);
    #1;
    // released lines must not keep the old value
    bus_out <= '{1'b1, 1'b1, 1'b1, 1'b1, ~a};
    dq_out  <= ~dat;
    @(posedge core_clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- verif/pbp_port_tb.sv ----
// self-checking testbench of the processor buffer port
`timescale 1ns/1ps
`default_nettype none
module pbp_port_tb;
  import pbp_pkg::*;
  logic              core_clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  pbp_bus_t          host_bus_in;
  logic [DATA_W-1:0] dq_in, dq_out, core_rx_data_out, core_tx_data_in, w;
  logic [DATA_W-1:0] rq[$], cq[$], d[4];
  logic              dq_oe_n_out, int_n_out, dma_request_out_n, dma_ack_in_n;
  logic              core_rx_valid_out, core_rx_ready_in, core_tx_valid_in, core_tx_ready_out;
  int                miscompares = 0;
  int                checked = 0;
  int                seed = 32'hf73f;
  always #4 core_clk_in = ~core_clk_in;
  pbp_host pbp_host_i (.core_clk_in, .bus_out(host_bus_in), .dq_out(dq_in));
  pbp_port #(.FIFO_DEPTH(4)) pbp_port_i (
    .core_clk_in, .rst_n_in, .host_bus_in, .dq_in, .dq_out, .dq_oe_n_out, .int_n_out,
    .dma_request_out_n, .dma_ack_in_n, .core_rx_data_out, .core_rx_valid_out,
    .core_rx_ready_in, .core_tx_data_in, .core_tx_valid_in, .core_tx_ready_out);
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // read a location, noting the word the port must return
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rq.push_back(e);
    pbp_host_i.acc(1'b0, a, DATA_ZERO);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    pbp_host_i.acc(1'b1, a, v);
  endtask
  // results appear on dq while driven and on the rx side when taken
  always @(posedge core_clk_in) begin
    if (rst_n_in && dq_oe_n_out === 1'b0 && rq.size() > 0) chk(dq_out, rq.pop_front());
    if (core_rx_valid_out === 1'b1 && core_rx_ready_in === 1'b1 && cq.size() > 0) begin
      chk(core_rx_data_out, cq.pop_front());
    end
  end
  initial begin
    dma_ack_in_n = 1'b1;
    core_rx_ready_in = 1'b0;
    core_tx_valid_in = 1'b0;
    core_tx_data_in = DATA_ZERO;
    repeat (20) @(posedge core_clk_in);
    #1;
    rst_n_in = 1'b1;
    rd(ADDR_CFG, DATA_W'(CFG_RESET));
    rd(ADDR_MASK, DATA_W'(MASK_RESET));
    rd(ADDR_EVT, 16'h0002);
    wr(ADDR_READY, 16'hffff);
    rd(ADDR_READY, 16'h0002);
    rd(ADDR_RDY_ADDR, 16'h00ff);
    rd(8'h55, DATA_ZERO);
    chk(DATA_W'(int_n_out), 16'h0001);
    $display("register test done");
    wr(ADDR_MASK, 16'h000f);
    tick(1);
    chk(DATA_W'(int_n_out), DATA_ZERO);
    chk(DATA_W'(dma_request_out_n), 16'h0001);
    wr(ADDR_EVT, 16'h0002);
    tick(1);
    chk(DATA_W'(int_n_out), 16'h0001);
    $display("interrupt test done");
    core_tx_valid_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      d[i] = DATA_W'($random(seed));
      core_tx_data_in = d[i];
      tick(1);
    end
    core_tx_valid_in = 1'b0;
    chk(DATA_W'(core_tx_ready_out), DATA_ZERO);
    tick(1);
    chk(DATA_W'(int_n_out), DATA_ZERO);
    rd(ADDR_READY, 16'h0003);
    rd(ADDR_RDY_ADDR, 16'h0001);
    wr(ADDR_CFG, 16'h0003);
    tick(1);
    chk(DATA_W'(dma_request_out_n), DATA_ZERO);
    chk(DATA_W'(int_n_out), 16'h0001);
    for (int i = 0; i < 4; i++) rd(ADDR_EP_RD, d[i]);
    rd(ADDR_EP_RD, DATA_ZERO);
    rd(ADDR_EVT, 16'h0009);
    $display("read buffer test done");
    for (int i = 0; i < 5; i++) begin
      w = DATA_W'($random(seed));
      if (i < 4) cq.push_back(w);
      dma_ack_in_n = (i != 0);
      wr(dma_ack_in_n ? ADDR_EP_WR : ADDR_NONE, w);
    end
    tick(1);
    chk(DATA_W'(dma_request_out_n), 16'h0001);
    rd(ADDR_EVT, 16'h000d);
    core_rx_ready_in = 1'b1;
    for (int n = 0; n < 50 && cq.size() > 0; n++) tick(1);
    tick(2);
    chk(DATA_W'(dma_request_out_n), DATA_ZERO);
    chk(DATA_W'(rq.size() + cq.size()), DATA_ZERO);
    $display("write buffer test done");
    finish_test();
  end
endmodule
`default_nettype wire
